// *** logic/cpu_regfile_consts.vh ***
// Constants of the banked processor register file: selectors, bit
// positions, reset values and bus offsets.
// Assumes inclusion by bare name from the design files under logic/.
// What this block does
// RL1 - User mode normally, privileged on exceptions
// RL2 - Sixteen general registers, lower eight banked
// RL3 - Bank bit picks privileged bank zero or one
// RL4 - Privileged mode with bank bit one: bank one serves
// RL5 - Bank bit zero: bank zero serves
// RL6 - User mode always uses bank zero
// RL7 - Global base and status open in both modes
// RL8 - Saved, vector base and debug base registers privileged only
// RL9 - Some status bits privileged only
// RL10 - System registers open in every mode
// RL11 - Thirty-two float registers in two sets
// RL12 - Front set as pairs or vectors
// RL13 - Extended set as pairs or matrix
// RL14 - Privilege bit selects the processor mode
// RL15 - Status word reset values defined
// RL16 - Reset loads counter, vector base, float control
// RL17 - Bank decode uses current mode bits
`ifndef CPU_REGFILE_CONSTS_VH
`define CPU_REGFILE_CONSTS_VH

// Control and system register selectors
`define CR_GLOBAL_BASE 4'h0
`define CR_STATUS 4'h1
`define CR_SAVED_STATUS 4'h2
`define CR_SAVED_PC 4'h3
`define CR_VECTOR_BASE 4'h4
`define CR_SAVED_R15 4'h5
`define CR_DEBUG_BASE 4'h6
`define CR_MAC_HIGH 4'h7
`define CR_MAC_LOW 4'h8
`define CR_RETURN_LINK 4'h9
`define CR_PROGRAM_COUNTER 4'hA
`define CR_FLOAT_STATUS 4'hB
`define CR_FLOAT_TRANSFER 4'hC

// Status word fields
`define SW_PRIV_BIT 30
`define SW_BANK_BIT 29
`define SW_BLOCK_BIT 28
`define SW_FDIS_BIT 15
`define SW_INTERRUPT_MASK_LEVEL_LSB 4
`define SW_INTERRUPT_MASK_LEVEL_MSB 7
`define SW_VALID_MASK 32'h700083F3
`define SW_USER_MASK 32'h00000303
`define SW_RESET 32'h700000F0

// Float status word: bank swap bit
`define FSC_BANK_BIT 21

// Reset values
`define PC_RESET 32'hA0000000
`define VBR_RESET 32'h00000000
`define FSC_RESET 32'h00040001

// Bus offsets
`define OFS_STATUS 8'h00
`define OFS_PC 8'h04
`define OFS_VBR 8'h08
`define OFS_FSC 8'h0C
`define OFS_FAULT 8'h10

// Float read views
`define FV_SINGLE 2'h0
`define FV_PAIR 2'h1
`define FV_VECTOR 2'h2

`endif

// *** logic/float_reg_bank.v ***
// Two-bank float register store with single, pair, vector and matrix views.
// Assumes one clock and a bank swap level from the float status word.
`timescale 1ns/1ps
`include "cpu_regfile_consts.vh"
module float_reg_bank
(
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Bank swap
  input wire swap,
  // Read side
  input wire rd_en,
  input wire rd_ext,
  input wire [3:0] rd_num,
  input wire [1:0] rd_view,
  output reg [127:0] rd_data,
  // Write side
  input wire wr_en,
  input wire wr_ext,
  input wire wr_pair,
  input wire [3:0] wr_num,
  input wire [63:0] wr_data,
  // Whole extended set
  output reg [511:0] matrix
);

reg [31:0] fpr_reg [0:31];
reg [127:0] rd_next;
integer i;
integer j;

function [4:0] slot;
  input ext;
  input sel;
  input [3:0] num;
  begin
    slot = {ext ^ sel, num};
  end
endfunction

////////////////////////////////////////////////////////////////////////
// RL11 two bank store
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    for (i = 0; i < 32; i = i + 1)
      fpr_reg[i] <= 32'h00000000;
  end
  else if (wr_en)
  begin
    if (wr_pair)
    begin
      fpr_reg[slot(wr_ext, swap, {wr_num[3:1], 1'b0})] <= wr_data[63:32];
      fpr_reg[slot(wr_ext, swap, {wr_num[3:1], 1'b1})] <= wr_data[31:0];
    end
    else
      fpr_reg[slot(wr_ext, swap, wr_num)] <= wr_data[31:0];
  end
end

////////////////////////////////////////////////////////////////////////
// RL12 pair and vector views
always @*
begin
  rd_next = 128'h0;
  case (rd_view)
    `FV_PAIR:
      rd_next[63:0] = {fpr_reg[slot(rd_ext, swap, {rd_num[3:1], 1'b0})],
                       fpr_reg[slot(rd_ext, swap, {rd_num[3:1], 1'b1})]};
    `FV_VECTOR:
      rd_next = {fpr_reg[slot(rd_ext, swap, {rd_num[3:2], 2'h0})],
                 fpr_reg[slot(rd_ext, swap, {rd_num[3:2], 2'h1})],
                 fpr_reg[slot(rd_ext, swap, {rd_num[3:2], 2'h2})],
                 fpr_reg[slot(rd_ext, swap, {rd_num[3:2], 2'h3})]};
    default:
      rd_next[31:0] = fpr_reg[slot(rd_ext, swap, rd_num)];
  endcase
end

// RL13 extended matrix view
always @*
begin
  matrix = 512'h0;
  for (j = 0; j < 16; j = j + 1)
    matrix[511 - 32 * j -: 32] = fpr_reg[slot(1'b1, swap, j[3:0])];
end

always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
    rd_data <= 128'h0;
  else if (rd_en)
    rd_data <= rd_next;
end

endmodule

// *** logic/banked_cpu_register_file.v ***
// Architectural register file: banked general registers, control and
// system registers with mode checks, float store, APB debug window.
// Assumes the pipeline and the APB master share CORE_CLK.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "cpu_regfile_consts.vh"
module banked_cpu_register_file
(
  // Clock and reset
  input wire CORE_CLK,
  input wire ARST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output reg PSLVERR,
  // Exception entry and return
  input wire EXC_ENTER,
  input wire EXC_RETURN,
  input wire [31:0] EXC_PC,
  // Program counter
  input wire PC_LOAD,
  input wire [31:0] PC_NEXT,
  output wire [31:0] PC_VALUE,
  // General registers
  input wire GR_RD_EN,
  input wire [3:0] GR_RD_NUM,
  output reg [31:0] GR_RD_DATA,
  input wire GR_WR_EN,
  input wire [3:0] GR_WR_NUM,
  input wire [31:0] GR_WR_DATA,
  // Other bank via control loads and stores
  input wire ALT_RD_EN,
  input wire ALT_WR_EN,
  input wire [2:0] ALT_NUM,
  input wire [31:0] ALT_WR_DATA,
  output reg [31:0] ALT_RD_DATA,
  // Control and system registers
  input wire CR_RD_EN,
  input wire CR_WR_EN,
  input wire [3:0] CR_SEL,
  input wire [31:0] CR_WR_DATA,
  output reg [31:0] CR_RD_DATA,
  output reg ACCESS_FAULT,
  // Float registers
  input wire FP_RD_EN,
  input wire FP_RD_EXT,
  input wire [3:0] FP_RD_NUM,
  input wire [1:0] FP_RD_VIEW,
  output wire [127:0] FP_RD_DATA,
  input wire FP_WR_EN,
  input wire FP_WR_EXT,
  input wire FP_WR_PAIR,
  input wire [3:0] FP_WR_NUM,
  input wire [63:0] FP_WR_DATA,
  output wire [511:0] FP_MATRIX,
  // Mode state
  output wire PRIV_MODE,
  output wire BANK_SEL,
  output wire BLOCK_INT,
  output wire FLOAT_DISABLE,
  output wire [3:0] INT_MASK_LEVEL
);

reg [31:0] gr_reg [0:23];
reg [31:0] status_reg, status_next;
reg [31:0] global_base_reg, saved_status_reg, saved_pc_reg, vector_base_reg;
reg [31:0] saved_r15_reg, debug_base_reg, mac_high_reg, mac_low_reg;
reg [31:0] return_link_reg, pc_reg, fsc_reg, transfer_reg;
reg fault_reg, apb_err_next;
reg [31:0] cr_rd_next, apb_rd_next;
wire priv, rb, cr_denied, alt_denied, cr_wr_ok;
wire alt_wr_ok, apb_setup, apb_wr, fault_event;
integer i;

////////////////////////////////////////////////////////////////////////
// Decode helpers

// RL17 bank from current mode bits
function [4:0] gr_slot;
  input [3:0] num;
  input md;
  input bank;
  begin
    if (num[3])
      gr_slot = {2'b10, num[2:0]};
    // RL4 bank one when privileged and bit set
    else if (md && bank)
      gr_slot = {2'b01, num[2:0]};
    // RL5 bank zero when bit clear
    else
      gr_slot = {2'b00, num[2:0]};
  end
endfunction

// RL3 other bank for control moves
function [4:0] alt_slot;
  input [2:0] num;
  input bank;
  begin
    alt_slot = {1'b0, ~bank, num};
  end
endfunction

// RL8 privileged control registers
function cr_is_priv;
  input [3:0] sel;
  begin
    case (sel)
      `CR_SAVED_STATUS, `CR_SAVED_PC, `CR_VECTOR_BASE,
      `CR_SAVED_R15, `CR_DEBUG_BASE:
        cr_is_priv = 1'b1;
      // RL7 RL10 open in both modes
      default:
        cr_is_priv = 1'b0;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Mode and access checks

// RL14 privilege bit sets mode
assign priv = status_reg[`SW_PRIV_BIT];
assign rb = status_reg[`SW_BANK_BIT];
assign cr_denied = (CR_RD_EN | CR_WR_EN) & cr_is_priv(CR_SEL) & ~priv;
// RL6 bank one closed in user mode
assign alt_denied = (ALT_RD_EN | ALT_WR_EN) & ~priv;
assign cr_wr_ok = CR_WR_EN & ~cr_denied;
assign alt_wr_ok = ALT_WR_EN & priv;
assign fault_event = cr_denied | alt_denied;

assign PRIV_MODE = priv;
assign BANK_SEL = rb;
assign BLOCK_INT = status_reg[`SW_BLOCK_BIT];
assign FLOAT_DISABLE = status_reg[`SW_FDIS_BIT];
assign INT_MASK_LEVEL = status_reg[`SW_INTERRUPT_MASK_LEVEL_MSB:`SW_INTERRUPT_MASK_LEVEL_LSB];
assign PC_VALUE = pc_reg;

////////////////////////////////////////////////////////////////////////
// Status word next value
always @*
begin
  status_next = status_reg;
  // RL1 exception enters privileged mode
  if (EXC_ENTER)
    status_next = (status_reg | (32'h1 << `SW_PRIV_BIT) | (32'h1 << `SW_BANK_BIT)
                  | (32'h1 << `SW_BLOCK_BIT)) & `SW_VALID_MASK;
  else if (EXC_RETURN)
    status_next = saved_status_reg & `SW_VALID_MASK;
  else if (cr_wr_ok && CR_SEL == `CR_STATUS)
  begin
    // RL9 user writes keep privileged bits
    if (priv)
      status_next = CR_WR_DATA & `SW_VALID_MASK;
    else
      status_next = (status_reg & ~`SW_USER_MASK) | (CR_WR_DATA & `SW_USER_MASK);
  end
  else if (apb_wr && PADDR == `OFS_STATUS)
    status_next = PWDATA & `SW_VALID_MASK;
end

////////////////////////////////////////////////////////////////////////
// Control and system registers
always @(posedge CORE_CLK or negedge ARST_N)
begin
  if (!ARST_N)
  begin
    // RL15 status word reset
    status_reg <= `SW_RESET;
    // RL16 reset loads fixed values
    pc_reg <= `PC_RESET;
    vector_base_reg <= `VBR_RESET;
    fsc_reg <= `FSC_RESET;
    {global_base_reg, saved_status_reg, saved_pc_reg} <= 96'h0;
    {saved_r15_reg, debug_base_reg, mac_high_reg} <= 96'h0;
    {mac_low_reg, return_link_reg, transfer_reg} <= 96'h0;
  end
  else
  begin
    status_reg <= status_next;
    if (EXC_ENTER)
    begin
      saved_status_reg <= status_reg;
      saved_pc_reg <= EXC_PC;
      saved_r15_reg <= gr_reg[5'h17];
    end
    else if (cr_wr_ok)
    begin
      case (CR_SEL)
        `CR_SAVED_STATUS: saved_status_reg <= CR_WR_DATA;
        `CR_SAVED_PC: saved_pc_reg <= CR_WR_DATA;
        `CR_SAVED_R15: saved_r15_reg <= CR_WR_DATA;
        default: saved_r15_reg <= saved_r15_reg;
      endcase
    end
    if (cr_wr_ok)
    begin
      case (CR_SEL)
        `CR_GLOBAL_BASE: global_base_reg <= CR_WR_DATA;
        `CR_VECTOR_BASE: vector_base_reg <= CR_WR_DATA;
        `CR_DEBUG_BASE: debug_base_reg <= CR_WR_DATA;
        `CR_MAC_HIGH: mac_high_reg <= CR_WR_DATA;
        `CR_MAC_LOW: mac_low_reg <= CR_WR_DATA;
        `CR_RETURN_LINK: return_link_reg <= CR_WR_DATA;
        `CR_FLOAT_STATUS: fsc_reg <= CR_WR_DATA;
        `CR_FLOAT_TRANSFER: transfer_reg <= CR_WR_DATA;
        default: transfer_reg <= transfer_reg;
      endcase
    end
    // Return restores the counter before any plain load
    if (EXC_RETURN)
      pc_reg <= saved_pc_reg;
    else if (PC_LOAD)
      pc_reg <= PC_NEXT;
  end
end

// RL10 system registers read freely
always @*
begin
  case (CR_SEL)
    `CR_GLOBAL_BASE: cr_rd_next = global_base_reg;
    `CR_STATUS: cr_rd_next = status_reg;
    `CR_SAVED_STATUS: cr_rd_next = saved_status_reg;
    `CR_SAVED_PC: cr_rd_next = saved_pc_reg;
    `CR_VECTOR_BASE: cr_rd_next = vector_base_reg;
    `CR_SAVED_R15: cr_rd_next = saved_r15_reg;
    `CR_DEBUG_BASE: cr_rd_next = debug_base_reg;
    `CR_MAC_HIGH: cr_rd_next = mac_high_reg;
    `CR_MAC_LOW: cr_rd_next = mac_low_reg;
    `CR_RETURN_LINK: cr_rd_next = return_link_reg;
    `CR_PROGRAM_COUNTER: cr_rd_next = pc_reg;
    `CR_FLOAT_STATUS: cr_rd_next = fsc_reg;
    `CR_FLOAT_TRANSFER: cr_rd_next = transfer_reg;
    default: cr_rd_next = 32'h00000000;
  endcase
end

// RL8 denied reads return zero
always @(posedge CORE_CLK or negedge ARST_N)
begin
  if (!ARST_N)
  begin
    CR_RD_DATA <= 32'h00000000;
    ACCESS_FAULT <= 1'b0;
  end
  else
  begin
    ACCESS_FAULT <= fault_event;
    if (CR_RD_EN)
      CR_RD_DATA <= cr_denied ? 32'h00000000 : cr_rd_next;
  end
end

////////////////////////////////////////////////////////////////////////
// General registers
// RL2 24 cells: two banks and shared upper eight
always @(posedge CORE_CLK or negedge ARST_N)
begin
  if (!ARST_N)
  begin
    for (i = 0; i < 24; i = i + 1)
      gr_reg[i] <= 32'h00000000;
  end
  else
  begin
    // RL3 control moves reach the idle bank
    if (alt_wr_ok)
      gr_reg[alt_slot(ALT_NUM, rb)] <= ALT_WR_DATA;
    // Plain write wins if both hit one cell
    if (GR_WR_EN)
      gr_reg[gr_slot(GR_WR_NUM, priv, rb)] <= GR_WR_DATA;
  end
end

always @(posedge CORE_CLK or negedge ARST_N)
begin
  if (!ARST_N)
  begin
    GR_RD_DATA <= 32'h00000000;
    ALT_RD_DATA <= 32'h00000000;
  end
  else
  begin
    // RL17 read decode
    if (GR_RD_EN)
      GR_RD_DATA <= gr_reg[gr_slot(GR_RD_NUM, priv, rb)];
    // RL6 user reads of the idle bank give zero
    if (ALT_RD_EN)
      ALT_RD_DATA <= priv ? gr_reg[alt_slot(ALT_NUM, rb)] : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////
// Float registers
// RL11 bank swap from float status
float_reg_bank float_reg_bank_i
(
  .clk(CORE_CLK),
  .arst_n(ARST_N),
  .swap(fsc_reg[`FSC_BANK_BIT]),
  .rd_en(FP_RD_EN),
  .rd_ext(FP_RD_EXT),
  .rd_num(FP_RD_NUM),
  .rd_view(FP_RD_VIEW),
  .rd_data(FP_RD_DATA),
  .wr_en(FP_WR_EN),
  .wr_ext(FP_WR_EXT),
  .wr_pair(FP_WR_PAIR),
  .wr_num(FP_WR_NUM),
  .wr_data(FP_WR_DATA),
  .matrix(FP_MATRIX)
);

////////////////////////////////////////////////////////////////////////
// APB debug window
// Zero wait states; data and error are registered in the setup cycle
assign PREADY = 1'b1;
assign apb_setup = PSEL & ~PENABLE;
assign apb_wr = PSEL & PENABLE & PWRITE;

always @*
begin
  apb_err_next = 1'b0;
  case (PADDR)
    `OFS_STATUS: apb_rd_next = status_reg;
    `OFS_PC: apb_rd_next = pc_reg;
    `OFS_VBR: apb_rd_next = vector_base_reg;
    `OFS_FSC: apb_rd_next = fsc_reg;
    `OFS_FAULT: apb_rd_next = {31'h0, fault_reg};
    default:
    begin
      apb_rd_next = 32'h00000000;
      apb_err_next = 1'b1;
    end
  endcase
end

always @(posedge CORE_CLK or negedge ARST_N)
begin
  if (!ARST_N)
  begin
    PRDATA <= 32'h00000000;
    PSLVERR <= 1'b0;
    fault_reg <= 1'b0;
  end
  else
  begin
    if (apb_setup)
    begin
      PRDATA <= PWRITE ? 32'h00000000 : apb_rd_next;
      PSLVERR <= apb_err_next;
    end
    // New fault beats a write-one clear
    if (fault_event)
      fault_reg <= 1'b1;
    else if (apb_wr && PADDR == `OFS_FAULT && PWDATA[0])
      fault_reg <= 1'b0;
  end
end

endmodule

// *** tb/pipe_model.sv ***
// Pipeline-side partner: issues register file requests one at a time.
// Assumes callers wait on CORE_CLK; every task ends one step past an edge.
`timescale 1ns/1ps
module pipe_model
(
  // Clock
  input logic CORE_CLK,
  // Requests
  output logic EXC_ENTER, EXC_RETURN, PC_LOAD, GR_RD_EN, GR_WR_EN,
  output logic ALT_RD_EN, ALT_WR_EN, CR_RD_EN, CR_WR_EN,
  output logic FP_RD_EN, FP_RD_EXT, FP_WR_EN, FP_WR_EXT, FP_WR_PAIR,
  output logic [31:0] EXC_PC, PC_NEXT, GR_WR_DATA, ALT_WR_DATA, CR_WR_DATA,
  output logic [3:0] GR_RD_NUM, GR_WR_NUM, CR_SEL, FP_RD_NUM, FP_WR_NUM,
  output logic [2:0] ALT_NUM,
  output logic [1:0] FP_RD_VIEW,
  output logic [63:0] FP_WR_DATA,
  // Answers
  input logic [31:0] GR_RD_DATA, ALT_RD_DATA, CR_RD_DATA
);
  initial
  begin
    {EXC_ENTER, EXC_RETURN, PC_LOAD, GR_RD_EN, GR_WR_EN, ALT_RD_EN, ALT_WR_EN} = '0;
    {CR_RD_EN, CR_WR_EN, FP_RD_EN, FP_RD_EXT, FP_WR_EN, FP_WR_EXT, FP_WR_PAIR} = '0;
    {EXC_PC, PC_NEXT, GR_WR_DATA, ALT_WR_DATA, CR_WR_DATA, FP_WR_DATA} = '0;
    {GR_RD_NUM, GR_WR_NUM, CR_SEL, FP_RD_NUM, FP_WR_NUM, ALT_NUM, FP_RD_VIEW} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Idle data lines are inverted so a stale value never looks valid
  task automatic wr(input [1:0] k, input [3:0] n, input [31:0] d);
    @(posedge CORE_CLK);
    GR_WR_EN <= k == 0;
    ALT_WR_EN <= k == 1;
    CR_WR_EN <= k == 2;
    {GR_WR_NUM, CR_SEL, ALT_NUM} <= {n, n, n[2:0]};
    {GR_WR_DATA, ALT_WR_DATA, CR_WR_DATA} <= {3{d}};
    @(posedge CORE_CLK);
    {GR_WR_EN, ALT_WR_EN, CR_WR_EN} <= 3'h0;
    {GR_WR_DATA, ALT_WR_DATA, CR_WR_DATA} <= {3{~d}};
    #1;
  endtask
  task automatic rd(input [1:0] k, input [3:0] n, output logic [31:0] q);
    @(posedge CORE_CLK);
    GR_RD_EN <= k == 0;
    ALT_RD_EN <= k == 1;
    CR_RD_EN <= k == 2;
    {GR_RD_NUM, CR_SEL, ALT_NUM} <= {n, n, n[2:0]};
    @(posedge CORE_CLK);
    {GR_RD_EN, ALT_RD_EN, CR_RD_EN} <= 3'h0;
    #1;
    q = k == 0 ? GR_RD_DATA : k == 1 ? ALT_RD_DATA : CR_RD_DATA;
  endtask
  task automatic sys(input e, input r, input l, input [31:0] v);
    @(posedge CORE_CLK);
    {EXC_ENTER, EXC_RETURN, PC_LOAD} <= {e, r, l};
    {EXC_PC, PC_NEXT} <= {v, v};
    @(posedge CORE_CLK);
    {EXC_ENTER, EXC_RETURN, PC_LOAD} <= 3'h0;
    {EXC_PC, PC_NEXT} <= {~v, ~v};
    #1;
  endtask
  task automatic fw(input x, input p, input [3:0] n, input [63:0] d);
    @(posedge CORE_CLK);
    {FP_WR_EN, FP_WR_EXT, FP_WR_PAIR, FP_WR_NUM, FP_WR_DATA} <= {1'b1, x, p, n, d};
    @(posedge CORE_CLK);
    FP_WR_EN <= 1'b0;
    FP_WR_DATA <= ~d;
    #1;
  endtask
  task automatic fr(input x, input [3:0] n, input [1:0] v);
    @(posedge CORE_CLK);
    {FP_RD_EN, FP_RD_EXT, FP_RD_NUM, FP_RD_VIEW} <= {1'b1, x, n, v};
    @(posedge CORE_CLK);
    FP_RD_EN <= 1'b0;
    #1;
  endtask
endmodule

// *** tb/regfile_chk.sv ***
// Port assertions for the banked register file.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module regfile_chk
(
  input logic CORE_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input logic EXC_ENTER, EXC_RETURN, PC_LOAD, ALT_RD_EN, ALT_WR_EN,
  input logic CR_RD_EN, CR_WR_EN, ACCESS_FAULT, PRIV_MODE, BANK_SEL, BLOCK_INT,
  input logic FLOAT_DISABLE, FP_WR_EN, FP_WR_EXT, FP_WR_PAIR,
  input logic [7:0] PADDR,
  input logic [3:0] CR_SEL, FP_WR_NUM, INT_MASK_LEVEL,
  input logic [31:0] PRDATA, PC_NEXT, PC_VALUE, CR_RD_DATA,
  input logic [63:0] FP_WR_DATA,
  input logic [511:0] FP_MATRIX
);
  logic [31:0] fp_lo;
  assign fp_lo = FP_WR_DATA[31:0];
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  property p_reset;
    $rose(ARST_N) |-> PC_VALUE == 32'hA0000000 && PRIV_MODE && BANK_SEL && BLOCK_INT
      && !FLOAT_DISABLE && INT_MASK_LEVEL == 4'hF;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_enter;
    EXC_ENTER |=> PRIV_MODE && BANK_SEL && BLOCK_INT;
  endproperty
  a_enter: assert property (p_enter) else $error("entry mode wrong");
  property p_cr_deny;
    CR_RD_EN && !PRIV_MODE && CR_SEL inside {[4'h2:4'h6]} |=> ACCESS_FAULT && CR_RD_DATA == 0;
  endproperty
  a_cr_deny: assert property (p_cr_deny) else $error("user read not refused");
  property p_alt_deny;
    (ALT_RD_EN || ALT_WR_EN) && !PRIV_MODE |=> ACCESS_FAULT;
  endproperty
  a_alt_deny: assert property (p_alt_deny) else $error("user bank access no fault");
  property p_open;
    CR_RD_EN && CR_SEL inside {4'h0, 4'h1, [4'h7:4'hC]} && !CR_WR_EN && !ALT_RD_EN
      && !ALT_WR_EN |=> !ACCESS_FAULT;
  endproperty
  a_open: assert property (p_open) else $error("open register faulted");
  property p_pc_rd;
    CR_RD_EN && CR_SEL == 4'hA |=> CR_RD_DATA == $past(PC_VALUE);
  endproperty
  a_pc_rd: assert property (p_pc_rd) else $error("counter read wrong");
  property p_pc_load;
    PC_LOAD && !EXC_RETURN |=> PC_VALUE == $past(PC_NEXT);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("counter load wrong");
  property p_user_sw;
    CR_WR_EN && CR_SEL == 4'h1 && !PRIV_MODE && !EXC_ENTER && !EXC_RETURN
      && !(PSEL && PENABLE && PWRITE) |=> !PRIV_MODE && BANK_SEL == $past(BANK_SEL)
      && BLOCK_INT == $past(BLOCK_INT);
  endproperty
  a_user_sw: assert property (p_user_sw) else $error("user changed guarded bits");
  property p_err;
    s_setup ##0 PADDR > 8'h10 ##1 s_access |-> PSLVERR && PREADY;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_apb_pc;
    s_setup ##0 !PWRITE && PADDR == 8'h04 ##1 s_access |-> PRDATA == $past(PC_VALUE);
  endproperty
  a_apb_pc: assert property (p_apb_pc) else $error("bus counter read wrong");
  property p_fp;
    FP_WR_EN && FP_WR_EXT && !FP_WR_PAIR && FP_WR_NUM == 4'h0
      |=> FP_MATRIX[511:480] == $past(fp_lo);
  endproperty
  a_fp: assert property (p_fp) else $error("matrix view wrong");
endmodule
bind banked_cpu_register_file regfile_chk regfile_chk_i (.*);

// *** tb/test_banked_cpu_register_file.sv ***
// Self-checking bench: APB master tasks and pipeline calls with expectations.
// Assumes the pipeline partner model and the bound checker.
`timescale 1ns/1ps
module test_banked_cpu_register_file;
  logic CORE_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, PC_VALUE, GR_RD_DATA, ALT_RD_DATA, CR_RD_DATA;
  logic PREADY, PSLVERR, ACCESS_FAULT, PRIV_MODE, BANK_SEL, BLOCK_INT, FLOAT_DISABLE;
  logic EXC_ENTER, EXC_RETURN, PC_LOAD, GR_RD_EN, GR_WR_EN, ALT_RD_EN, ALT_WR_EN;
  logic CR_RD_EN, CR_WR_EN, FP_RD_EN, FP_RD_EXT, FP_WR_EN, FP_WR_EXT, FP_WR_PAIR;
  logic [31:0] EXC_PC, PC_NEXT, GR_WR_DATA, ALT_WR_DATA, CR_WR_DATA, q;
  logic [3:0] GR_RD_NUM, GR_WR_NUM, CR_SEL, FP_RD_NUM, FP_WR_NUM, INT_MASK_LEVEL;
  logic [2:0] ALT_NUM;
  logic [1:0] FP_RD_VIEW;
  logic [63:0] FP_WR_DATA;
  logic [127:0] FP_RD_DATA;
  logic [511:0] FP_MATRIX;
  logic e;
  logic [31:0] rv [4] = '{32'h700000F0, 32'hA0000000, 32'h0, 32'h00040001};
  logic [3:0] cs [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hC};
  int bad_count = 0, checks = 0;
  banked_cpu_register_file banked_cpu_register_file_i (.*);
  pipe_model pipe_model_i (.*);
  initial forever #5 CORE_CLK = ~CORE_CLK;
  //////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic apb(input w, input [7:0] a, input [31:0] d);
    int i;
    @(posedge CORE_CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge CORE_CLK);
      if (PREADY === 1'b1)
        break;
    end
    if (i == 16)
    begin
      bad_count++;
      close_out;
    end
    {q, e} = {PRDATA, PSLVERR};
    {PSEL, PENABLE, PWDATA} <= {2'h0, ~d};
    #1;
  endtask
  task automatic ap(input w, input [7:0] a, input [31:0] d, input [31:0] x, input xe);
    apb(w, a, d);
    if (!w)
      chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic rc(input [1:0] k, input [3:0] n, input [31:0] x, input xf);
    pipe_model_i.rd(k, n, q);
    chk(q, x);
    chk({31'h0, ACCESS_FAULT}, {31'h0, xf});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    for (int i = 0; i < 4; i++)
      ap(0, 8'(i * 4), 0, rv[i], 0);
    ap(0, 8'h14, 0, 0, 1);
    pipe_model_i.wr(0, 3, 32'hA1);
    pipe_model_i.wr(0, 8, 32'hC8);
    ap(1, 8'h00, 32'h500000F0, 0, 0);
    pipe_model_i.wr(0, 3, 32'hB0);
    rc(0, 3, 32'hB0, 0);
    rc(1, 3, 32'hA1, 0);
    ap(1, 8'h00, 32'h700000F0, 0, 0);
    rc(0, 3, 32'hA1, 0);
    rc(1, 3, 32'hB0, 0);
    pipe_model_i.wr(1, 5, 32'h55);
    ap(1, 8'h00, 32'h000000F0, 0, 0);
    rc(0, 3, 32'hB0, 0);
    rc(0, 5, 32'h55, 0);
    rc(0, 8, 32'hC8, 0);
    rc(1, 3, 0, 1);
    for (int s = 2; s < 7; s++)
      rc(2, s[3:0], 0, 1);
    pipe_model_i.wr(2, 4, 32'h77);
    chk({31'h0, ACCESS_FAULT}, 1);
    ap(0, 8'h08, 0, 0, 0);
    foreach (cs[j])
    begin
      pipe_model_i.wr(2, cs[j], 32'h100 + cs[j]);
      rc(2, cs[j], 32'h100 + cs[j], 0);
    end
    rc(2, 4'hA, 32'hA0000000, 0);
    rc(2, 4'hB, 32'h00040001, 0);
    pipe_model_i.wr(2, 1, 32'h700003F3);
    ap(0, 8'h00, 0, 32'h000003F3, 0);
    pipe_model_i.sys(1, 0, 0, 32'h80000040);
    chk({29'h0, PRIV_MODE, BANK_SEL, BLOCK_INT}, 32'h7);
    rc(2, 2, 32'h000003F3, 0);
    rc(2, 3, 32'h80000040, 0);
    rc(0, 3, 32'hA1, 0);
    pipe_model_i.wr(2, 4, 32'h80);
    ap(0, 8'h08, 0, 32'h80, 0);
    pipe_model_i.sys(0, 1, 0, 0);
    chk(PC_VALUE, 32'h80000040);
    chk({31'h0, PRIV_MODE}, 0);
    pipe_model_i.sys(0, 0, 1, 32'h1000);
    chk(PC_VALUE, 32'h1000);
    ap(0, 8'h10, 0, 1, 0);
    ap(1, 8'h10, 1, 0, 0);
    ap(0, 8'h10, 0, 0, 0);
    pipe_model_i.fw(1, 0, 0, 64'h1111);
    chk(FP_MATRIX[511:480], 32'h1111);
    pipe_model_i.fw(0, 1, 2, {32'hD2, 32'hD3});
    pipe_model_i.fr(0, 2, 1);
    chk(FP_RD_DATA[63:32], 32'hD2);
    chk(FP_RD_DATA[31:0], 32'hD3);
    pipe_model_i.fr(0, 0, 2);
    chk(FP_RD_DATA[127:96], 0);
    chk(FP_RD_DATA[63:32], 32'hD2);
    pipe_model_i.fw(1, 1, 4, {32'hE4, 32'hE5});
    chk(FP_MATRIX[351:320], 32'hE5);
    pipe_model_i.wr(2, 4'hB, 32'h00240001);
    pipe_model_i.fr(0, 0, 0);
    chk(FP_RD_DATA[31:0], 32'h1111);
    chk(FP_MATRIX[511:480], 0);
    close_out;
  end
endmodule
